// ==== core/tsb_core.sv ====
// Summary of operation
// - output is a trapezoid with equal rise and fall plus a separate flat top.
// - peaking time is rise code clamped to 1..8 (5..8 when decimated) times 0.8 us times decimation factor 1..16.
// - flat-top code 0..15 gives 0.2..3.2 us, scaled by decimation.
// - shaper is FIR; a passed pulse leaves no trace in the output.
// - auto-baseline disconnects input on preamp reset, averages offset, applies it.
// - pulse processing is suspended while a preamp reset is in progress.
// - restorer sums samples below baseline; at threshold adds an upward step.
// - restorer periodically subtracts a downward step from the baseline.
// - up step, down step and threshold each have four selectable settings.
// - pile-up detection uses a parallel purely digital fast channel.
// - dead time comes only from shaping; peak capture adds none.
// - pile-up interval is rise time plus 20% of it plus flat top.
// - rejection off: two events inside the interval give one combined peak.
// - rejection on: events more than 600 ns up to interval apart are both discarded.
// - only fast-channel events above the fast threshold trigger pile-up logic.
// - samples arrive at 20 MHz and one is consumed per sample slot.
// - one peak value is emitted per accepted shaped pulse.
//
// The implementer's own choices: register access over Wishbone and the address map.
`include "tsb_defs.svh"

module tsb_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [11:0] adc_i,
    input wire logic preamp_reset_i,
    output logic detector_disconnect_o,
    output logic [21:0] shaped_o,
    output logic [21:0] peak_o,
    output logic peak_valid_o
);
    localparam int PPR_CLK = `TSB_PPR_CLK;

    tsb_pkg::tsb_state_t s_q;
    tsb_pkg::tsb_state_t s_d;
    logic signed [13:0] dl_q [0:511];

    logic susp_w;
    logic smp_w;
    logic dstb_w;
    logic above_w;
    logic wr_w;
    logic signed [13:0] xr_w;
    logic signed [13:0] dx_w;
    logic signed [17:0] dsum_w;
    logic signed [14:0] fast_w;
    logic [7:0] k_w;
    logic [7:0] m_w;
    logic [2:0] dec_w;
    logic [31:0] rd_w;

    function automatic logic [2:0] dec_eff(input tsb_pkg::tsb_ctrl_t c);
        return (c.dec > 3'h4) ? 3'h4 : c.dec;
    endfunction : dec_eff

    function automatic logic [7:0] rise_len(input tsb_pkg::tsb_ctrl_t c);
        logic [3:0] r;
        r = (c.rise == 4'h0) ? 4'h1 : ((c.rise > 4'h8) ? 4'h8 : c.rise);
        if (c.dec != 3'h0 && r < 4'h5) begin
            r = 4'h5;
        end
        return 8'(r * `TSB_RISE_UNIT);
    endfunction : rise_len

    function automatic logic [7:0] flat_len(input tsb_pkg::tsb_ctrl_t c);
        return 8'((c.flat + 5'h01) * `TSB_FLAT_UNIT);
    endfunction : flat_len

    // interval in decimated samples, then clocks
    function automatic logic [13:0] ivl_clk(input logic [7:0] k, input logic [7:0] m,
                                            input logic [2:0] d);
        logic [13:0] n;
        n = {6'h0, k} + {6'h0, k} / 14'd5 + {6'h0, m};
        return 14'((n << d) * `TSB_CLK_PER_SMP);
    endfunction : ivl_clk

    // taps not yet filled read as zero so a restart leaves no stale history
    function automatic logic signed [21:0] tap(input logic [8:0] d);
        return (s_q.fill >= d) ? 22'(dl_q[9'(s_q.wp - d)]) : 22'sh0;
    endfunction : tap

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] v,
                                           input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = v[i*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    function automatic logic [19:0] pow2(input logic [4:0] e);
        return 20'h1 << e;
    endfunction : pow2

    always_comb begin
        s_d = s_q;
        s_d.fev = 1'b0;
        s_d.peak.valid = 1'b0;
        s_d.adc_m = adc_i;
        s_d.adc_s = s_q.adc_m;
        s_d.prst_m = preamp_reset_i;
        s_d.prst_s = s_q.prst_m;
        s_d.prst_d = s_q.prst_s;
        k_w = rise_len(s_q.ctrl);
        m_w = flat_len(s_q.ctrl);
        dec_w = dec_eff(s_q.ctrl);
        s_d.ph = ~s_q.ph;
        smp_w = s_q.ph;
        susp_w = s_q.prst_s | (s_q.ab != tsb_pkg::AB_IDLE);
        xr_w = susp_w ? 14'sh0 : ($signed({2'b0, s_q.adc_s}) - $signed({2'b0, s_q.base[19:8]}));
        dsum_w = s_q.dacc + 18'(xr_w);
        dx_w = 14'(dsum_w >>> dec_w);
        dstb_w = smp_w && (s_q.dcnt == 4'((5'h1 << dec_w) - 5'h1));
        fast_w = 15'(xr_w) - 15'(s_q.fd[`TSB_FAST_LAG - 1]);
        above_w = fast_w > $signed({1'b0, s_q.fthr});

        // decimating front end and trapezoid recursion
        if (smp_w) begin
            s_d.dcnt = dstb_w ? 4'h0 : s_q.dcnt + 4'h1;
            s_d.dacc = dstb_w ? 18'sh0 : dsum_w;
        end
        if (dstb_w) begin
            s_d.wp = s_q.wp + 9'h1;
            s_d.fill = (s_q.fill == 9'h1ff) ? s_q.fill : s_q.fill + 9'h1;
            s_d.y = s_q.y + 22'(dx_w) - tap({1'b0, k_w})
                    - tap(9'({1'b0, k_w} + {1'b0, m_w}))
                    + tap(9'({1'b0, k_w} + {1'b0, k_w} + {1'b0, m_w}));
        end

        // restorer, 1/256-LSB scale steps keep resolution loss small
        if (smp_w && s_q.ctrl.rest_en && !susp_w) begin
            s_d.dncnt = s_q.dncnt + 8'h1;
            if (xr_w < 0) begin
                s_d.racc = s_q.racc + 18'(-xr_w);
            end
            if ({2'b0, s_q.racc} >= pow2(5'(`TSB_THR_LOG2 + 2 * s_q.ctrl.thr_sel))) begin
                s_d.racc = 18'h0;
                s_d.base = s_q.base + pow2(5'(`TSB_UP_LOG2 + s_q.ctrl.up_sel));
            end else if (s_q.dncnt == `TSB_DN_PERIOD
                         && s_q.base >= pow2(5'(`TSB_DN_LOG2 + s_q.ctrl.dn_sel))) begin
                s_d.base = s_q.base - pow2(5'(`TSB_DN_LOG2 + s_q.ctrl.dn_sel));
            end
        end

        // auto-baseline offset capture around a preamp reset
        case (s_q.ab)
            tsb_pkg::AB_IDLE: begin
                if (s_q.ctrl.auto_en && s_q.prst_s && !s_q.prst_d) begin
                    s_d.ab = tsb_pkg::AB_AVG;
                    s_d.abn = 4'h0;
                    s_d.aacc = 16'h0;
                end
            end
            tsb_pkg::AB_AVG: begin
                if (smp_w) begin
                    s_d.aacc = s_q.aacc + {4'h0, s_q.adc_s};
                    s_d.abn = s_q.abn + 4'h1;
                    if (s_q.abn == 4'hf) begin
                        s_d.base = {12'((s_q.aacc + {4'h0, s_q.adc_s}) >> `TSB_AB_LOG2),
                                    8'h0};
                        s_d.ab = tsb_pkg::AB_HOLD;
                    end
                end
            end
            tsb_pkg::AB_HOLD: begin
                if (!s_q.prst_s) begin
                    s_d.ab = tsb_pkg::AB_IDLE;
                end
            end
            default: s_d.ab = tsb_pkg::AB_IDLE;
        endcase

        // fast channel: rising threshold crossing is an event
        if (smp_w) begin
            s_d.fd = {s_q.fd[`TSB_FAST_LAG - 2:0], xr_w};
            s_d.fabove = above_w;
            s_d.fev = above_w && !s_q.fabove && !susp_w;
        end

        // peak window and pile-up
        if (s_q.pp != 5'h1f) begin
            s_d.pp = s_q.pp + 5'h1;
        end
        if (s_q.busy) begin
            s_d.pk = (s_q.y > s_q.pk) ? s_q.y : s_q.pk;
            s_d.win = s_q.win - 14'h1;
            if (s_q.win == 14'h1) begin
                s_d.busy = 1'b0;
                if (s_q.pile) begin
                    s_d.rej = s_q.rej + 16'h1;
                end else begin
                    s_d.peak.value = (s_q.y > s_q.pk) ? s_q.y : s_q.pk;
                    s_d.peak.valid = 1'b1;
                end
            end
        end
        if (s_q.fev) begin
            s_d.pp = 5'h0;
            if (!s_q.busy || s_q.win == 14'h1) begin
                // a window may open on the edge the previous one closes
                s_d.busy = 1'b1;
                s_d.win = ivl_clk(k_w, m_w, dec_w);
                s_d.pk = s_q.y;
                s_d.pile = 1'b0;
            end else if (s_q.ctrl.pileup_en && s_q.pp >= 5'(PPR_CLK)) begin
                s_d.pile = 1'b1;
            end
        end

        // wishbone slave, one wait state
        wr_w = cyc_i && stb_i && !s_q.ack;
        s_d.ack = wr_w;
        case (adr_i)
            `TSB_ADR_CTRL: rd_w = s_q.ctrl;
            `TSB_ADR_FTHR: rd_w = {16'h0, s_q.fthr};
            `TSB_ADR_STAT: rd_w = {17'h0, s_q.pile, s_q.busy, susp_w, s_q.base[19:8]};
            `TSB_ADR_PEAK: rd_w = {10'h0, s_q.peak.value};
            `TSB_ADR_REJ: rd_w = {16'h0, s_q.rej};
            default: rd_w = 32'h0;
        endcase
        if (wr_w) begin
            s_d.rdat = we_i ? 32'h0 : rd_w;
        end
        if (wr_w && we_i) begin
            // is left to software; both modes may be set
            if (adr_i == `TSB_ADR_CTRL) begin
                s_d.ctrl = wmerge(s_q.ctrl, dat_i, sel_i);
                // new timing invalidates the history, so the pipe restarts
                s_d.fill = 9'h0;
                s_d.y = 22'sh0;
                s_d.dcnt = 4'h0;
                s_d.dacc = 18'sh0;
            end
            if (adr_i == `TSB_ADR_FTHR) begin
                s_d.fthr = 16'(wmerge({16'h0, s_q.fthr}, dat_i, sel_i));
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.ctrl <= `TSB_CTRL_RST;
            s_q.fthr <= `TSB_FTHR_RST;
            s_q.ab <= tsb_pkg::AB_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (dstb_w) begin
            dl_q[s_q.wp] <= dx_w;
        end
    end

    assign dat_o = s_q.rdat;
    assign ack_o = s_q.ack;
    assign detector_disconnect_o = (s_q.ab == tsb_pkg::AB_AVG);
    assign shaped_o = s_q.y;
    assign peak_o = s_q.peak.value;
    assign peak_valid_o = s_q.peak.valid;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_peak_single: assert property (peak_valid_o |=> !peak_valid_o)
        else $error("peak valid longer than one cycle");
    chk_susp_no_start: assert property (susp_w |-> ##2 !$rose(s_q.busy))
        else $error("window opened during suspension");
    chk_ab_disc: assert property ($rose(detector_disconnect_o)
        |-> detector_disconnect_o[*8] ##[22:26] !detector_disconnect_o)
        else $error("offset averaging wrong length");
    chk_base_hold: assert property ((!s_q.ctrl.rest_en && !s_q.ctrl.auto_en
        && s_q.ab == tsb_pkg::AB_IDLE) |=> $stable(s_q.base))
        else $error("baseline moved with both modes off");
    chk_pile_off: assert property (!s_q.ctrl.pileup_en |=> !$rose(s_q.pile))
        else $error("pile-up flagged while rejection off");
    chk_ppr_merge: assert property ((s_q.fev && s_q.busy && s_q.win != 14'h1
        && s_q.pp < 5'(PPR_CLK)) |=> s_q.pile == $past(s_q.pile))
        else $error("close pair treated as pile-up");
    chk_emit_end: assert property ((s_q.busy && s_q.win == 14'h1 && !s_q.pile)
        |=> peak_valid_o && peak_o == $past((s_q.y > s_q.pk) ? s_q.y : s_q.pk))
        else $error("clean window gave no peak");
    chk_fast_thr: assert property (s_q.fev |-> $past(above_w) && !$past(susp_w))
        else $error("event without fast threshold crossing");
    chk_reject_cnt: assert property ((s_q.busy && s_q.win == 14'h1 && s_q.pile)
        |=> s_q.rej == $past(s_q.rej) + 16'h1 && !peak_valid_o)
        else $error("piled window not rejected");
endmodule : tsb_core

// ==== dv/tb_trapezoid_shaper_blr_pileup.sv ====
`include "tsb_defs.svh"

module tb_trapezoid_shaper_blr_pileup;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, preamp_reset_i;
    logic detector_disconnect_o, peak_valid_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd, r0;
    logic [11:0] adc_i, level, offset;
    logic [21:0] shaped_o, peak_o, pv;
    int n_errors = 0;
    int cmp_count = 0;
    int c, n;
    int k_tab[4] = '{16, 128, 80, 80};
    logic [31:0] ctl_tab[4] = '{32'h0000_0001, 32'h0000_0008, 32'h0000_0101, 32'h0000_0205};

    tsb_core tsb_core_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .adc_i(adc_i), .preamp_reset_i(preamp_reset_i),
        .detector_disconnect_o(detector_disconnect_o), .shaped_o(shaped_o),
        .peak_o(peak_o), .peak_valid_o(peak_valid_o));
    tsb_adc_model tsb_adc_model_inst (.clk_i(clk_i), .level_i(level), .offset_i(offset),
        .disconnect_i(detector_disconnect_o), .adc_o(adc_i));

    task automatic test_done();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // ack looked at mid-cycle, request dropped at the following rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(negedge clk_i);
            i++;
        end while (ack_o !== 1'b1 && i < 20);
        rd = dat_o;
        @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (i >= 20) begin
            n_errors++;
            test_done();
        end
    endtask : bus

    task automatic peaks(input int lim);
        c = 0;
        repeat (lim) begin
            @(negedge clk_i);
            if (peak_valid_o === 1'b1) begin
                c++;
                pv = peak_o;
            end
        end
    endtask : peaks

    task automatic pair(input logic [11:0] a, input int gap, input logic [11:0] b);
        @(posedge clk_i);
        level <= a;
        repeat (gap) @(posedge clk_i);
        level <= b;
    endtask : pair

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial begin
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, preamp_reset_i} = 4'h0;
        adr_i = 8'h00;
        sel_i = 4'hf;
        dat_i = 32'h0;
        level = 12'h000;
        offset = 12'h000;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, `TSB_ADR_CTRL, 32'h0);
        chk(rd, 32'h0000_0001);
        bus(1'b0, `TSB_ADR_FTHR, 32'h0);
        chk(rd, 32'h0000_0040);
        bus(1'b1, 8'h20, 32'hffff_ffff);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, `TSB_ADR_PEAK, 32'hffff_ffff);
        bus(1'b0, `TSB_ADR_PEAK, 32'h0);
        chk(rd, 32'h0);
        $display("test registers done");
        // rise 1 and 8 undecimated, rise 1 clamped to 5 and rise 5 decimated
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `TSB_ADR_CTRL, ctl_tab[i]);
            repeat (300) @(posedge clk_i);
            pair(12'd100, 1, 12'd100);
            peaks(k_tab[i] * 20);
            chk(c, 1);
            chk(pv, 32'(k_tab[i] * 100));
            chk(shaped_o, 32'h0);
            level <= 12'd0;
            repeat (k_tab[i] * 20) @(posedge clk_i);
        end
        $display("test shaping done");
        bus(1'b1, `TSB_ADR_CTRL, 32'h0000_20f1);
        bus(1'b0, `TSB_ADR_REJ, 32'h0);
        r0 = rd;
        repeat (300) @(posedge clk_i);
        pair(12'd100, 40, 12'd200);
        peaks(400);
        chk(c, 0);
        bus(1'b0, `TSB_ADR_REJ, 32'h0);
        chk(rd, r0 + 32'h1);
        level <= 12'd0;
        repeat (400) @(posedge clk_i);
        // closer than pair resolution: one event
        pair(12'd100, 10, 12'd200);
        peaks(400);
        chk(c, 1);
        chk(pv, 32'd3200);
        level <= 12'd0;
        repeat (400) @(posedge clk_i);
        bus(1'b1, `TSB_ADR_CTRL, 32'h0000_00f1);
        repeat (300) @(posedge clk_i);
        pair(12'd100, 40, 12'd200);
        peaks(400);
        chk(c, 1);
        chk(pv, 32'd3200);
        $display("test pile-up done");
        offset <= 12'h123;
        level <= 12'h123;
        repeat (400) @(posedge clk_i);
        bus(1'b1, `TSB_ADR_CTRL, 32'h0000_0801);
        preamp_reset_i <= 1'b1;
        n = 0;
        while (detector_disconnect_o !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        chk(detector_disconnect_o, 32'h1);
        n = 0;
        while (detector_disconnect_o === 1'b1 && n < 60) begin
            @(negedge clk_i);
            n++;
        end
        chk(32'(n >= 31 && n <= 33), 32'h1);
        pair(12'h187, 1, 12'h187);
        peaks(200);
        chk(c, 0);
        bus(1'b0, `TSB_ADR_STAT, 32'h0);
        chk(rd[12], 32'h1);
        chk(rd[11:0], 32'h123);
        preamp_reset_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        bus(1'b0, `TSB_ADR_STAT, 32'h0);
        chk(rd[12], 32'h0);
        $display("test auto-baseline done");
        level <= 12'h000;
        bus(1'b1, `TSB_ADR_CTRL, 32'h0000_d001);
        bus(1'b0, `TSB_ADR_STAT, 32'h0);
        r0 = rd;
        repeat (2000) @(posedge clk_i);
        bus(1'b0, `TSB_ADR_STAT, 32'h0);
        chk(32'(rd[11:0] > r0[11:0]), 32'h1);
        r0 = rd;
        level <= 12'hfff;
        bus(1'b1, `TSB_ADR_CTRL, 32'h0003_d001);
        repeat (40000) @(posedge clk_i);
        bus(1'b0, `TSB_ADR_STAT, 32'h0);
        chk(32'(rd[11:0] < r0[11:0]), 32'h1);
        $display("test restorer done");
        test_done();
    end
endmodule : tb_trapezoid_shaper_blr_pileup

// ==== dv/tsb_adc_model.sv ====
module tsb_adc_model (
    input wire logic clk_i,
    input wire logic [11:0] level_i,
    input wire logic [11:0] offset_i,
    input wire logic disconnect_i,
    output logic [11:0] adc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ph_q = 1'b0;
    initial adc_o = 12'h000;
    // converts on every second edge: 20 MHz out of the 40 MHz clock
    always @(posedge clk_i) begin
        ph_q <= ~ph_q;
        if (ph_q) begin
            // a detached front end shows only its own offset
            adc_o <= disconnect_i ? offset_i : level_i;
        end
    end
endmodule : tsb_adc_model

// ==== shared/tsb_defs.svh ====
`ifndef TSB_DEFS_SVH
`define TSB_DEFS_SVH
`define TSB_ADR_CTRL 8'h00
`define TSB_ADR_FTHR 8'h04
`define TSB_ADR_STAT 8'h08
`define TSB_ADR_PEAK 8'h0c
`define TSB_ADR_REJ 8'h10
`define TSB_CTRL_RST 32'h0000_0001
`define TSB_FTHR_RST 16'h0040
`define TSB_CLK_MHZ 40
`define TSB_ADC_MHZ 20
`define TSB_CLK_PER_SMP (`TSB_CLK_MHZ / `TSB_ADC_MHZ)
`define TSB_RISE_NS 800
`define TSB_FLAT_NS 200
`define TSB_RISE_UNIT (`TSB_RISE_NS * `TSB_ADC_MHZ / 1000)
`define TSB_FLAT_UNIT (`TSB_FLAT_NS * `TSB_ADC_MHZ / 1000)
`define TSB_PPR_NS 600
`define TSB_PPR_CLK ((`TSB_PPR_NS * `TSB_CLK_MHZ + 999) / 1000)
`define TSB_FAST_LAG 4
`define TSB_AB_LOG2 4
`define TSB_DN_PERIOD 8'hff
`define TSB_UP_LOG2 1
`define TSB_DN_LOG2 0
`define TSB_THR_LOG2 6
`endif

// ==== shared/tsb_pkg.sv ====
package tsb_pkg;
    typedef enum logic [1:0] {AB_IDLE, AB_AVG, AB_HOLD} tsb_ab_t;

    typedef struct packed {
        logic [11:0] rsvd;
        logic [1:0] thr_sel;
        logic [1:0] dn_sel;
        logic [1:0] up_sel;
        logic pileup_en;
        logic rest_en;
        logic auto_en;
        logic [2:0] dec;
        logic [3:0] flat;
        logic [3:0] rise;
    } tsb_ctrl_t;

    typedef struct packed {
        logic [21:0] value;
        logic valid;
    } tsb_peak_t;

    typedef struct packed {
        tsb_ctrl_t ctrl;
        logic [15:0] fthr;
        logic ack;
        logic [31:0] rdat;
        logic [11:0] adc_m;
        logic [11:0] adc_s;
        logic prst_m;
        logic prst_s;
        logic prst_d;
        logic ph;
        logic [3:0] dcnt;
        logic signed [17:0] dacc;
        logic [8:0] wp;
        logic [8:0] fill;
        logic signed [21:0] y;
        logic [19:0] base;
        logic [17:0] racc;
        logic [7:0] dncnt;
        tsb_ab_t ab;
        logic [3:0] abn;
        logic [15:0] aacc;
        logic [3:0][13:0] fd;
        logic fabove;
        logic fev;
        logic busy;
        logic pile;
        logic [13:0] win;
        logic [4:0] pp;
        logic signed [21:0] pk;
        tsb_peak_t peak;
        logic [15:0] rej;
    } tsb_state_t;
endpackage : tsb_pkg
